// >>> design/led_ctrl_pkg.sv
// Purpose: Constants for the indicator blink / pulse-stretch control block
// Assumes: 20 MHz clock, classic Wishbone register access with 32-bit data
// Notes: Word offsets are byte addresses; unused register bits read as zero
//
// How it works
// - Rate field bits 11:10 picks blink 2.5/5/10/20 Hz; reset code 01.
// - Same rate field picks pulse-stretch 400/200/100/50 ms for codes 00..11.
// - Only port zero's rate field is used, for every indicator on every port.
// - Bit 12 set gates active indicators with 5 kHz programmable duty; reset 0.
// - Bits 8 and 7 choose stretch (1) or blink (0) for indicators three, two.
// - Bits 6 and 5 choose stretch (1) or blink (0) for indicators one, zero.

package led_ctrl_pkg;

   // ==========================================================================
   // Structure
   localparam int NUM_PORTS = 4;
   localparam int NUM_IND = 4;
   localparam int NUM_PINS = NUM_PORTS * NUM_IND;

   // ==========================================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL_BASE = 8'h00;
   localparam logic [7:0] ADDR_DUTY = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // ==========================================================================
   // Control register fields
   localparam int PULSE_BIT = 12;
   localparam int RATE_LSB = 10;
   localparam int STYLE_LSB = 5;
   localparam logic [15:0] CTRL_RW_MASK = 16'h1DE0;
   localparam logic [15:0] CTRL_RESET = 16'h0400;
   localparam logic [11:0] DUTY_RESET = 12'h7D0;

   // ==========================================================================
   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYC = CLK_HZ / MS_PER_S;
   localparam int PWM_HZ = 5000;
   localparam int PWM_CYC = CLK_HZ / PWM_HZ;
   localparam logic [11:0] PWM_LAST = 12'(PWM_CYC - 1);

   // Blink rates in tenths of Hz, half period derived in ms
   localparam int BLINK_DHZ [4] = '{25, 50, 100, 200};
   localparam int DHZ_HALF_MS = 5000;
   localparam logic [7:0] BLINK_HALF_MS [4] = '{
      8'(DHZ_HALF_MS / 25), 8'(DHZ_HALF_MS / 50), 8'(DHZ_HALF_MS / 100), 8'(DHZ_HALF_MS / 200)};

   // Pulse-stretch durations in ms
   localparam logic [8:0] STRETCH_MS [4] = '{9'h190, 9'h0C8, 9'h064, 9'h032};

endpackage

// >>> design/led_ctrl.sv
// Purpose: Indicator blink / pulse-stretch control with Wishbone registers
// Assumes: Activity inputs come from pins; soft_rst_i is a one-clock pulse from logic
// Notes: Registers at 0x00..0x0C are per-port control, 0x10 duty, 0x14 status
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns

module led_ctrl #(
   parameter int TICK_CYC = led_ctrl_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic soft_rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Activity in, indicators out (index = port*4 + indicator)
   input wire logic [15:0] act_i,
   output logic [15:0] ind_o
);

   // ==========================================================================
   // Bus slave
   logic ack_q;
   logic [31:0] dat_q;
   logic [15:0] ctrl_q [led_ctrl_pkg::NUM_PORTS];
   logic [11:0] duty_q;
   logic [15:0] act_m_q;
   logic [15:0] act_s_q;
   logic [15:0] ind_q;

   wire req = cyc_i & stb_i;
   wire ack_d = req & ~ack_q;
   wire wr_en = req & we_i & ack_q;
   wire hit_ctrl = adr_i[7:4] == led_ctrl_pkg::ADDR_CTRL_BASE[7:4];
   wire hit_duty = adr_i[7:2] == led_ctrl_pkg::ADDR_DUTY[7:2];
   wire hit_stat = adr_i[7:2] == led_ctrl_pkg::ADDR_STATUS[7:2];
   wire [1:0] port_sel = adr_i[3:2];
   wire [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   wire [15:0] ctrl_mask = lane_mask & led_ctrl_pkg::CTRL_RW_MASK;
   wire [11:0] duty_mask = lane_mask[11:0];
   wire [31:0] rd_data = hit_ctrl ? {16'h0000, ctrl_q[port_sel]} :
                         hit_duty ? {20'h00000, duty_q} :
                         hit_stat ? {ind_q, act_s_q} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         if (ack_d) begin
            dat_q <= rd_data;
         end
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // Control registers keep their value through a soft reset
   genvar p;
   generate
      for (p = 0; p < led_ctrl_pkg::NUM_PORTS; p++) begin : g_ctrl
         wire ctrl_wr = wr_en & hit_ctrl & (port_sel == 2'(p));
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               ctrl_q[p] <= led_ctrl_pkg::CTRL_RESET;
            end else if (ctrl_wr) begin
               ctrl_q[p] <= (ctrl_q[p] & ~ctrl_mask) | (dat_i[15:0] & ctrl_mask);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         duty_q <= led_ctrl_pkg::DUTY_RESET;
      end else if (wr_en & hit_duty) begin
         duty_q <= (duty_q & ~duty_mask) | (dat_i[11:0] & duty_mask);
      end
   end

   // ==========================================================================
   // Activity synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_m_q <= 16'h0000;
         act_s_q <= 16'h0000;
      end else begin
         act_m_q <= act_i;
         act_s_q <= act_m_q;
      end
   end

   // ==========================================================================
   // Global rate, taken from port zero only
   wire [1:0] rate_sel = ctrl_q[0][led_ctrl_pkg::RATE_LSB +: 2];
   wire [7:0] blink_half_ms = led_ctrl_pkg::BLINK_HALF_MS[rate_sel];
   wire [8:0] stretch_ms = led_ctrl_pkg::STRETCH_MS[rate_sel];

   // ==========================================================================
   // Millisecond tick, blink phase and 5 kHz modulation
   logic [15:0] tick_cnt_q;
   logic [7:0] blink_cnt_q;
   logic blink_phase_q;
   logic [11:0] pwm_cnt_q;

   wire ms_tick = tick_cnt_q == 16'(TICK_CYC - 1);
   wire blink_wrap = blink_cnt_q >= 8'(blink_half_ms - 8'h01);
   wire pwm_on = pwm_cnt_q < duty_q;

   always_ff @(posedge clk_i) begin
      if (rst_i || soft_rst_i) begin
         tick_cnt_q <= 16'h0000;
         blink_cnt_q <= 8'h00;
         blink_phase_q <= 1'b0;
         pwm_cnt_q <= 12'h000;
      end else begin
         tick_cnt_q <= ms_tick ? 16'h0000 : 16'(tick_cnt_q + 16'h0001);
         pwm_cnt_q <= (pwm_cnt_q == led_ctrl_pkg::PWM_LAST) ? 12'h000 : 12'(pwm_cnt_q + 12'h001);
         if (ms_tick) begin
            if (blink_wrap) begin
               blink_cnt_q <= 8'h00;
               blink_phase_q <= ~blink_phase_q;
            end else begin
               blink_cnt_q <= 8'(blink_cnt_q + 8'h01);
            end
         end
      end
   end

   // ==========================================================================
   // Per-indicator display
   logic [8:0] stretch_cnt_q [led_ctrl_pkg::NUM_PINS];
   wire [15:0] ind_d;

   genvar i;
   generate
      for (i = 0; i < led_ctrl_pkg::NUM_PINS; i++) begin : g_ind
         localparam int PORT = i / led_ctrl_pkg::NUM_IND;
         localparam int LED = i % led_ctrl_pkg::NUM_IND;
         wire use_stretch = ctrl_q[PORT][led_ctrl_pkg::STYLE_LSB + LED];
         wire pulse_en = ctrl_q[PORT][led_ctrl_pkg::PULSE_BIT];
         wire stretched = act_s_q[i] | (stretch_cnt_q[i] != 9'h000);
         wire blinked = act_s_q[i] & blink_phase_q;
         wire base_on = use_stretch ? stretched : blinked;
         assign ind_d[i] = base_on & (~pulse_en | pwm_on);

         always_ff @(posedge clk_i) begin
            if (rst_i || soft_rst_i) begin
               stretch_cnt_q[i] <= 9'h000;
            end else if (act_s_q[i]) begin
               stretch_cnt_q[i] <= stretch_ms;
            end else if (ms_tick && stretch_cnt_q[i] != 9'h000) begin
               stretch_cnt_q[i] <= 9'(stretch_cnt_q[i] - 9'h001);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i || soft_rst_i) begin
         ind_q <= 16'h0000;
      end else begin
         ind_q <= ind_d;
      end
   end

   assign ind_o = ind_q;

   // ==========================================================================
   // Assertions
   chk_blink_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      (ms_tick && blink_wrap && !soft_rst_i) |=> (blink_phase_q != $past(blink_phase_q)))
      else $error("blink phase did not toggle at half period");

   chk_rate_default: assert property (@(posedge clk_i)
      rst_i |=> (ctrl_q[0][11:10] == 2'h1 && ctrl_q[0][12] == 1'b0))
      else $error("rate or pulsing field wrong after reset");

   chk_stretch_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (act_s_q[0] && !soft_rst_i) |=> (stretch_cnt_q[0] == $past(stretch_ms)))
      else $error("stretch counter not loaded with rate duration");

   chk_rate_global: assert property (@(posedge clk_i) disable iff (rst_i)
      ($changed(ctrl_q[1]) && $stable(ctrl_q[0])) |-> $stable(stretch_ms) && $stable(blink_half_ms))
      else $error("other port rate field changed global rate");

   chk_pulse_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctrl_q[0][12] && !pwm_on && !soft_rst_i) |=> !ind_q[0] && !ind_q[3])
      else $error("indicator on while modulation is off");

   chk_pwm_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      (pwm_cnt_q == led_ctrl_pkg::PWM_LAST && !soft_rst_i) |=> pwm_cnt_q == 12'h000)
      else $error("modulation period wrong");

   chk_blink_style: assert property (@(posedge clk_i) disable iff (rst_i)
      (!soft_rst_i && !ctrl_q[0][12] && !ctrl_q[0][8] && act_s_q[3]) |=> ind_q[3] == $past(blink_phase_q))
      else $error("indicator three does not follow blink phase");

   chk_stretch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!soft_rst_i && !ctrl_q[0][12] && ctrl_q[0][5] && stretch_cnt_q[0] != 9'h000) |=> ind_q[0])
      else $error("indicator zero dropped during stretch");

   chk_soft_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      (soft_rst_i && !wr_en) |=> $stable(ctrl_q[0]) && $stable(ctrl_q[3]) && $stable(duty_q))
      else $error("control lost on soft reset");

   chk_resv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_q && $past(hit_ctrl)) |-> dat_o[9] == 1'b0 && dat_o[31:13] == 19'h00000)
      else $error("reserved control bits read nonzero");

   // ==========================================================================
   // Bus, counter and display checks

   chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_q |=> !ack_q)
      else $error("acknowledge longer than one cycle");

   chk_ack_request: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_q) |=> ack_q)
      else $error("request not acknowledged");

   chk_stretch_table: assert property (@(posedge clk_i) disable iff (rst_i)
      stretch_ms == (rate_sel == 2'h0 ? 9'h190 : rate_sel == 2'h1 ? 9'h0C8 : rate_sel == 2'h2 ? 9'h064 : 9'h032))
      else $error("stretch duration does not match rate code");

   chk_blink_table: assert property (@(posedge clk_i) disable iff (rst_i)
      blink_half_ms == (rate_sel == 2'h0 ? 8'hC8 : rate_sel == 2'h1 ? 8'h64 : rate_sel == 2'h2 ? 8'h32 : 8'h19))
      else $error("blink half period does not match rate code");

   chk_stretch_count: assert property (@(posedge clk_i) disable iff (rst_i)
      (!act_s_q[0] && !soft_rst_i && ms_tick && stretch_cnt_q[0] != 9'h000) |=>
      stretch_cnt_q[0] == 9'($past(stretch_cnt_q[0]) - 9'h001))
      else $error("stretch counter did not count down on tick");

   chk_stretch_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      (!act_s_q[0] && !ms_tick && !soft_rst_i) |=> $stable(stretch_cnt_q[0]))
      else $error("stretch counter moved between ticks");

   chk_tick_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      (ms_tick && !soft_rst_i) |=> tick_cnt_q == 16'h0000)
      else $error("millisecond counter did not wrap");

   chk_tick_bound: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_cnt_q < 16'(TICK_CYC))
      else $error("millisecond counter out of range");

   chk_pwm_bound: assert property (@(posedge clk_i) disable iff (rst_i)
      pwm_cnt_q <= led_ctrl_pkg::PWM_LAST)
      else $error("modulation counter out of range");

   chk_pulse_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      (!soft_rst_i && !ctrl_q[0][12] && ctrl_q[0][5] && act_s_q[0]) |=> ind_q[0])
      else $error("indicator zero dark without modulation");

   chk_blink_dark: assert property (@(posedge clk_i) disable iff (rst_i)
      (!soft_rst_i && !ctrl_q[0][5] && !blink_phase_q) |=> !ind_q[0])
      else $error("blinking indicator lit in dark phase");

   chk_idle_dark: assert property (@(posedge clk_i) disable iff (rst_i)
      (!soft_rst_i && !act_s_q[0] && stretch_cnt_q[0] == 9'h000) |=> !ind_q[0])
      else $error("idle indicator zero lit");

   chk_port_one: assert property (@(posedge clk_i) disable iff (rst_i)
      (act_s_q[4] && !soft_rst_i) |=> stretch_cnt_q[4] == $past(stretch_ms))
      else $error("port one stretch not from global rate");

   chk_soft_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      soft_rst_i |=> ind_q == 16'h0000 && !blink_phase_q)
      else $error("soft reset left display state");

   chk_resv_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctrl_q[0] & ~led_ctrl_pkg::CTRL_RW_MASK) == 16'h0000)
      else $error("reserved control bit set");

   chk_style_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit_ctrl && port_sel == 2'h0 && sel_i[1:0] == 2'h3) |=> ctrl_q[0][8:5] == $past(dat_i[8:5]))
      else $error("style bits not written");

   chk_rate_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit_ctrl && port_sel == 2'h0 && sel_i[1]) |=> ctrl_q[0][12:10] == $past(dat_i[12:10]))
      else $error("rate or pulsing bits not written");

   chk_stretch_style: assert property (@(posedge clk_i) disable iff (rst_i)
      (!soft_rst_i && !ctrl_q[0][12] && ctrl_q[0][8] && act_s_q[3]) |=> ind_q[3])
      else $error("stretching indicator three dark while active");

   cov_stretch_run: cover property (@(posedge clk_i) disable iff (rst_i)
      $fell(act_s_q[0]) ##1 ind_q[0]);
   cov_blink_toggle: cover property (@(posedge clk_i) disable iff (rst_i)
      act_s_q[3] && ms_tick && blink_wrap);
   cov_pulse_active: cover property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q[0][12] && ind_q[0]);
   cov_bus_write: cover property (@(posedge clk_i) disable iff (rst_i)
      wr_en && hit_ctrl);

endmodule // led_ctrl

// >>> test/led_sink.sv
// Purpose: Indicator lamp model that measures lit runs
// Assumes: One lamp per ind_o bit, lit while high
// Notes: run_o holds the length of the last lit run, fell_o pulses as it ends
`timescale 1ns/1ns

module led_sink (
   // Clock
   input wire logic clk_i,
   // Lamps
   input wire logic [15:0] ind_i,
   output logic [15:0][15:0] run_o,
   output logic [15:0] fell_o
);
   logic [15:0][15:0] cnt_q;
   logic [15:0] prev_q;

   always_ff @(posedge clk_i) begin
      prev_q <= ind_i;
      fell_o <= prev_q & ~ind_i;
      for (int k = 0; k < 16; k++) begin
         cnt_q[k] <= ind_i[k] ? cnt_q[k] + 16'h1 : 16'h0;
         if (prev_q[k] && !ind_i[k]) begin
            run_o[k] <= cnt_q[k];
         end
      end
   end
endmodule // led_sink

// >>> test/led_ctrl_tb.sv
// Purpose: Self-checking bench for the indicator control block
// Assumes: One ms is shortened to TK clocks
// Notes: Lit run lengths come from the lamp model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module led_ctrl_tb;
   localparam int TK = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic soft_rst_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [15:0] act_i = 16'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic [15:0] ind_o;
   logic [15:0][15:0] run;
   logic [15:0] fell;
   int num_errors = 0;
   int checked = 0;
   logic [31:0] seed = 32'h6665;
   logic [31:0] rd;

   always #25 clk_i = ~clk_i;

   led_ctrl #(.TICK_CYC(TK)) led_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .act_i(act_i), .ind_o(ind_o));
   led_sink led_sink_i (.clk_i(clk_i), .ind_i(ind_o), .run_o(run), .fell_o(fell));

   // ==========================================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] rmask(input logic [31:0] w);
      return {16'h0, w[15:0] & led_ctrl_pkg::CTRL_RW_MASK};
   endfunction

   function automatic logic in_rng(input logic [15:0] v, input int lo, input int hi);
      return (int'(v) >= lo) && (int'(v) <= hi);
   endfunction

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 100);
      if (n >= 100) begin num_errors++; $display("MISMATCH ack exp 1 got 0"); end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wait_fall(input int k);
      int n;
      n = 0;
      repeat (k) begin
         do begin @(posedge clk_i); n++; end while (fell[0] !== 1'b1 && n < 30000);
      end
      if (n >= 30000) begin num_errors++; $display("MISMATCH fall exp 1 got 0"); end
   endtask

   task automatic finish_test;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk_i);
      num_errors++;
      finish_test();
   end

   // ==========================================================================
   // Main sequence
   initial begin
      int lo;
      logic [31:0] w;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0, rd);
      `CHK("rate reset", 2'b01, rd[11:10])
      `CHK("pulse reset", 1'b0, rd[12])
      `CHK("style hi reset", 2'b00, rd[8:7])
      `CHK("style lo reset", 2'b00, rd[6:5])
      for (int p = 0; p < 4; p++) begin
         seed = lfsr(seed);
         w = seed;
         wb(1'b1, 8'(4 * p), w, rd);
         wb(1'b0, 8'(4 * p), 32'h0, rd);
         `CHK("ctrl rw", rmask(w), rd)
      end
      wb(1'b0, 8'h1C, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      soft_rst_i <= 1'b1;
      @(posedge clk_i);
      soft_rst_i <= 1'b0;
      wb(1'b0, 8'h0C, 32'h0, rd);
      `CHK("sticky", rmask(w), rd)
      // Stretch per code, port one holds the opposite code
      for (int r = 0; r < 4; r++) begin
         wb(1'b1, 8'h00, 32'((r << 10) | 32'h1A0), rd);
         wb(1'b1, 8'h04, 32'(((3 - r) << 10) | 32'h20), rd);
         act_i <= 16'h001D;
         repeat (10) @(posedge clk_i);
         act_i <= 16'h0;
         wait_fall(1);
         lo = 10 + int'(led_ctrl_pkg::STRETCH_MS[r]) * TK;
         `CHK("stretch", 1'b1, in_rng(run[0], lo - TK, lo + 4))
         `CHK("port one", run[0], run[4])
         `CHK("ind three", run[0], run[3])
         `CHK("ind two", run[0], run[2])
      end
      // Blink per code with activity held
      for (int r = 0; r < 4; r++) begin
         wb(1'b1, 8'h00, 32'(r << 10), rd);
         act_i <= 16'h0001;
         wait_fall(2);
         lo = int'(led_ctrl_pkg::BLINK_HALF_MS[r]) * TK;
         `CHK("blink", 1'b1, in_rng(run[0], lo - 1, lo + 1))
         act_i <= 16'h0;
      end
      // Pulsing at a random duty
      seed = lfsr(seed);
      lo = 200 + int'(seed % 3000);
      wb(1'b1, 8'h10, 32'(lo), rd);
      wb(1'b1, 8'h00, 32'h1020, rd);
      act_i <= 16'h0001;
      wait_fall(2);
      `CHK("pulsing", 1'b1, in_rng(run[0], lo - 1, lo + 1))
      wb(1'b0, 8'h10, 32'h0, rd);
      `CHK("duty", 32'(lo), rd)
      wb(1'b0, 8'h14, 32'h0, rd);
      `CHK("status act", 16'h0001, rd[15:0])
      act_i <= 16'h0;
      finish_test();
   end
endmodule // led_ctrl_tb
